//--- inc/flash_pwr_pkg.sv
// Purpose: shared constants and carriers for the flash power control registers
// Assumes: 32-bit ahb-lite data bus, byte address four times the printed offset
// Notes: widths fixed, no import used anywhere
package flash_pwr_pkg;
    // ==========================================================
    // register offsets
    localparam logic [11:0] ctrl_status_off = 12'h220; // control/status
    localparam logic [11:0] read_power_off = 12'h222; // printed offset, not word aligned
    localparam logic [11:0] ctrl_status_idx = 12'h220; // index form
    localparam logic [11:0] read_power_idx = 12'h222; // index form
    // ==========================================================
    // field positions
    localparam int ready_bit = 0; // ready flag
    localparam int rewrite_bit = 1; // rewrite enable
    localparam int lock_ovr_bit = 2; // lock override
    localparam int halt_bit = 3; // flash halt
    localparam int rsv4_bit = 4; // reserved, write 0
    localparam int rsv5_bit = 5; // reserved, boot dependent
    localparam int perr_bit = 6; // program error
    localparam int rsv7_bit = 7; // reserved, read undefined
    localparam int slow_bit = 2; // slow read
    localparam int lowi_bit = 3; // low current read
    // ==========================================================
    // reset values
    localparam logic [7:0] ctrl_rst_normal = 8'h01; // other boot modes
    localparam logic [7:0] ctrl_rst_user = 8'h21; // user boot mode
    localparam logic [3:0] pwr_rst_low = 4'h0; // low nibble after reset
    localparam logic [31:0] unmapped_data = 32'h0000_0000; // unmapped reads
    // ==========================================================
    // carriers
    typedef struct packed {
        logic valid; // write in data phase
        logic [7:0] data; // low byte of hwdata
    } byte_wr_t;
    typedef struct packed {
        logic busy; // program or erase running
        logic error; // last operation failed
    } seq_stat_t;
endpackage

//--- core/two_step_bit.sv
// Purpose: protected enable bit set only by a 0 then 1 write pair
// Assumes: wr pulses one cycle per register write
// Notes: clear always accepted, force_clr overrides
`timescale 1ns/1ps
`default_nettype none
module two_step_bit (
    input wire logic hclk, // bus clock
    input wire logic hresetn, // async reset, active low
    input wire logic wr, // write strobe to the owning register
    input wire logic wdat, // written bit value
    input wire logic force_clr, // hardware clear
    output logic q_ff // bit value
);
    logic armed_ff; // last write to this register wrote 0
    // ==========================================================
    // arm tracking: any other write breaks the pair
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed_ff <= 1'b0;
        end else if (wr) begin
            armed_ff <= ~wdat;
        end
    end
    // bit update: isolated 1 does nothing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_ff <= 1'b0;
        end else if (force_clr) begin
            q_ff <= 1'b0;
        end else if (wr && !wdat) begin
            q_ff <= 1'b0;
        end else if (wr && wdat && armed_ff) begin
            q_ff <= 1'b1;
        end
    end
    set_needs_pair_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(q_ff) |-> $past(wr) && $past(wdat) && $past(armed_ff))
        else $error("protected bit set without 0-1 pair");
endmodule // two_step_bit
`default_nettype wire

//--- core/ahb_slave_if.sv
// Purpose: ahb-lite slave front end, one cycle data phase, always okay
// Assumes: single word transfers only
// Notes: write strobe comes in the data phase
`timescale 1ns/1ps
`default_nettype none
module ahb_slave_if (
    input wire logic hclk, // bus clock
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [11:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic hready, // bus ready
    input wire logic [31:0] hwdata, // write data
    output logic [11:0] addr_ff, // latched address
    output logic wr_ff, // data phase write pending
    output logic rd_ff, // data phase read pending
    output logic hreadyout, // never stalls
    output logic hresp // always okay
);
    // ==========================================================
    // address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_ff <= 12'h000;
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
        end else if (hready) begin
            addr_ff <= haddr;
            wr_ff <= hsel && htrans[1] && hwrite;
            rd_ff <= hsel && htrans[1] && !hwrite;
        end
    end
    assign hreadyout = 1'b1; // zero wait states
    assign hresp = 1'b0; // okay
endmodule // ahb_slave_if
`default_nettype wire

//--- core/flash_power_control_regs.sv
// Purpose: flash control/status and read power registers behind ahb-lite
// Assumes: sequencer reports busy/error on the same clock
// Notes: a write hits a register when its data phase completes
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module flash_power_control_regs (
    input wire logic hclk, // bus clock, 25 mhz
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [11:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic [2:0] hsize, // size, word only
    input wire logic hready, // bus ready
    input wire logic [31:0] hwdata, // write data
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // response
    input wire logic user_boot, // boot mode strap, same clock
    input wire flash_pwr_pkg::seq_stat_t seq_stat, // sequencer status
    output logic cmd_accept_en, // sequencer may take commands
    output logic lock_override, // ignore block lock bits
    output logic flash_reset, // hold sequencer in reset
    output logic flash_access_block, // block array accesses
    output logic slow_read_en, // slow read mode
    output logic low_current_read_en // low current read mode
);
    // ==========================================================
    // bus front end
    logic [11:0] addr_ff; // data phase address
    logic wr_ff; // data phase write
    logic rd_ff; // data phase read
    flash_pwr_pkg::byte_wr_t ctrl_wr; // write to control/status
    flash_pwr_pkg::byte_wr_t pwr_wr; // write to read power
    ahb_slave_if u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .hwdata(hwdata),
        .addr_ff(addr_ff),
        .wr_ff(wr_ff),
        .rd_ff(rd_ff),
        .hreadyout(hreadyout),
        .hresp(hresp)
    );
    // decode used for writes and reads alike
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction
    // printed offsets are not all multiples of four, so byte address is 4*index
    localparam logic [11:0] ctrl_addr = 12'(flash_pwr_pkg::ctrl_status_idx << 2);
    localparam logic [11:0] pwr_addr = 12'(flash_pwr_pkg::read_power_idx << 2);
    always_comb begin
        ctrl_wr.valid = wr_ff && hit(addr_ff, ctrl_addr);
        ctrl_wr.data = hwdata[7:0];
        pwr_wr.valid = wr_ff && hit(addr_ff, pwr_addr);
        pwr_wr.data = hwdata[7:0];
    end
    // ==========================================================
    // boot strap capture after release
    logic boot_seen_ff; // strap already taken
    logic rsv5_ff; // reserved bit 5
    logic rsv4_ff; // reserved bit 4
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_seen_ff <= 1'b0;
            rsv5_ff <= 1'b0;
        end else if (!boot_seen_ff) begin
            boot_seen_ff <= 1'b1;
            rsv5_ff <= user_boot;
        end else if (ctrl_wr.valid) begin
            rsv5_ff <= ctrl_wr.data[flash_pwr_pkg::rsv5_bit];
        end
    end
    // bit 4 stores what is written; software keeps it 0
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rsv4_ff <= flash_pwr_pkg::ctrl_rst_normal[flash_pwr_pkg::rsv4_bit];
        end else if (ctrl_wr.valid) begin
            rsv4_ff <= ctrl_wr.data[flash_pwr_pkg::rsv4_bit];
        end
    end
    // ==========================================================
    // control/status plain bits
    logic lock_ff; // lock override
    logic halt_ff; // flash halt
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_ff <= flash_pwr_pkg::ctrl_rst_normal[flash_pwr_pkg::lock_ovr_bit];
            halt_ff <= flash_pwr_pkg::ctrl_rst_normal[flash_pwr_pkg::halt_bit];
        end else if (ctrl_wr.valid) begin
            lock_ff <= ctrl_wr.data[flash_pwr_pkg::lock_ovr_bit];
            halt_ff <= ctrl_wr.data[flash_pwr_pkg::halt_bit];
        end
    end
    // rewrite enable, protected; halt clears it with the control circuit
    logic rewrite_ff; // rewrite enable
    two_step_bit u_rewrite (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr(ctrl_wr.valid),
        .wdat(ctrl_wr.data[flash_pwr_pkg::rewrite_bit]),
        .force_clr(halt_ff),
        .q_ff(rewrite_ff)
    );
    // ==========================================================
    // read power register, both bits protected
    logic slow_ff; // slow read
    logic lowi_ff; // low current read
    logic [3:0] pwr_hi_ff; // upper nibble, stores writes
    two_step_bit u_slow (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr(pwr_wr.valid),
        .wdat(pwr_wr.data[flash_pwr_pkg::slow_bit]),
        .force_clr(1'b0),
        .q_ff(slow_ff)
    );
    two_step_bit u_lowi (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr(pwr_wr.valid),
        .wdat(pwr_wr.data[flash_pwr_pkg::lowi_bit]),
        .force_clr(1'b0),
        .q_ff(lowi_ff)
    );
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwr_hi_ff <= 4'h0; // undefined on reset, zero chosen
        end else if (pwr_wr.valid) begin
            pwr_hi_ff <= pwr_wr.data[7:4];
        end
    end
    logic [1:0] pwr_lo_ff; // bits 1:0, plain storage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwr_lo_ff <= flash_pwr_pkg::pwr_rst_low[1:0];
        end else if (pwr_wr.valid) begin
            pwr_lo_ff <= pwr_wr.data[1:0];
        end
    end
    // ==========================================================
    // outputs to the flash array and sequencer
    logic ready_flag; // live ready flag
    // halt resets the sequencer, so it shows ready while halted
    assign ready_flag = halt_ff | ~seq_stat.busy;
    // commands only while rewrite is on and flash is not halted
    assign cmd_accept_en = rewrite_ff & ~halt_ff;
    assign lock_override = lock_ff;
    assign flash_reset = halt_ff;
    assign flash_access_block = halt_ff;
    // read modes dropped while halted; software keeps them off in rewrite
    assign slow_read_en = slow_ff & ~halt_ff;
    assign low_current_read_en = lowi_ff & ~halt_ff;
    // ==========================================================
    // read data, registered by nothing: stable in data phase
    logic [7:0] ctrl_rd; // assembled control/status
    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[flash_pwr_pkg::ready_bit] = ready_flag;
        ctrl_rd[flash_pwr_pkg::rewrite_bit] = rewrite_ff;
        ctrl_rd[flash_pwr_pkg::lock_ovr_bit] = lock_ff;
        ctrl_rd[flash_pwr_pkg::halt_bit] = halt_ff;
        ctrl_rd[flash_pwr_pkg::rsv4_bit] = rsv4_ff;
        ctrl_rd[flash_pwr_pkg::rsv5_bit] = rsv5_ff;
        ctrl_rd[flash_pwr_pkg::perr_bit] = seq_stat.error;
        ctrl_rd[flash_pwr_pkg::rsv7_bit] = 1'b0;
    end
    always_comb begin
        if (rd_ff && hit(addr_ff, ctrl_addr)) begin
            hrdata = {24'h000000, ctrl_rd};
        end else if (rd_ff && hit(addr_ff, pwr_addr)) begin
            hrdata = {24'h000000, pwr_hi_ff, lowi_ff, slow_ff, pwr_lo_ff};
        end else begin
            hrdata = flash_pwr_pkg::unmapped_data;
        end
    end
    // ==========================================================
    // checks
    sequence halt_write_s;
        ctrl_wr.valid && ctrl_wr.data[flash_pwr_pkg::halt_bit];
    endsequence
    halt_blocks_flash_a: assert property (@(posedge hclk) disable iff (!hresetn)
        halt_write_s |=> flash_access_block && flash_reset && !cmd_accept_en)
        else $error("halt did not block flash");
    halt_clears_rewrite_a: assert property (@(posedge hclk) disable iff (!hresetn)
        halt_ff |=> !rewrite_ff)
        else $error("rewrite enable survived halt");
    cmd_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_accept_en |-> rewrite_ff && !halt_ff)
        else $error("commands accepted while disabled");
    ready_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_ff && hit(addr_ff, ctrl_addr) && seq_stat.busy && !halt_ff
        |-> !hrdata[flash_pwr_pkg::ready_bit])
        else $error("ready flag shown while busy");
    error_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_ff && hit(addr_ff, ctrl_addr)
        |-> hrdata[flash_pwr_pkg::perr_bit] == seq_stat.error)
        else $error("error flag mismatch");
    ro_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_wr.valid && !seq_stat.error ##1 rd_ff && hit(addr_ff, ctrl_addr)
        && !seq_stat.error |-> !hrdata[flash_pwr_pkg::perr_bit])
        else $error("write reached read-only flag");
    lock_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_wr.valid |=> lock_override == $past(ctrl_wr.data[flash_pwr_pkg::lock_ovr_bit]))
        else $error("lock override not written");
    boot_strap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(boot_seen_ff) |-> rsv5_ff == $past(user_boot))
        else $error("boot bit not captured");
    pwr_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !boot_seen_ff |-> !slow_ff && !lowi_ff && pwr_lo_ff == 2'b00)
        else $error("read power low nibble not clear");
    modes_halted_a: assert property (@(posedge hclk) disable iff (!hresetn)
        halt_ff |-> !slow_read_en && !low_current_read_en)
        else $error("read mode on while halted");
endmodule // flash_power_control_regs
`default_nettype wire

//--- verif/flash_power_control_regs_test.sv
// Purpose: self-checking bench for the flash power control registers
// Assumes: ahb-lite master of single word transfers, slave never stalls
// Notes: byte address is four times the printed register index
`timescale 1ns/1ps
`default_nettype none
module flash_power_control_regs_test;
    // ==========================================================
    // stimulus and observation
    logic hclk = 1'b0; // 25 mhz bus clock
    logic hresetn = 1'b0; // held low from time zero
    logic hsel = 1'b0; // slave select
    logic [11:0] haddr = 12'h000; // byte address
    logic [1:0] htrans = 2'b00; // idle at start
    logic hwrite = 1'b0; // write flag
    logic [2:0] hsize = 3'b010; // word transfers only
    logic [31:0] hwdata = 32'h0000_0000; // write data
    logic user_boot = 1'b0; // boot mode strap
    flash_pwr_pkg::seq_stat_t seq_stat = '0; // sequencer status
    logic [31:0] hrdata; // read data
    logic hreadyout; // slave ready, also the bus hready
    logic hresp; // response
    logic cmd_accept_en; // command acceptance
    logic lock_override; // lock bits ignored
    logic flash_reset; // sequencer held in reset
    logic flash_access_block; // array access blocked
    logic slow_read_en; // slow read
    logic low_current_read_en; // low current read
    logic [31:0] rd_smp; // read data taken at the closing edge
    logic [31:0] rd_val; // last read result
    int err_count = 0; // mismatches
    int checked = 0; // comparisons made
    // printed offsets are indices, so the byte address is four times that
    localparam logic [11:0] ctrl_addr = flash_pwr_pkg::ctrl_status_idx << 2; // control/status
    localparam logic [11:0] pwr_addr = flash_pwr_pkg::read_power_idx << 2; // read power
    localparam logic [11:0] hole_addr = 12'h884; // between the two, unmapped

    always #20 hclk = ~hclk; // 40 ns period

    // read data captured by the edge itself, so no race with the slave
    always @(posedge hclk) begin
        rd_smp <= hrdata;
    end

    flash_power_control_regs i_dut (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hreadyout),
        .hwdata(hwdata),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .user_boot(user_boot),
        .seq_stat(seq_stat),
        .cmd_accept_en(cmd_accept_en),
        .lock_override(lock_override),
        .flash_reset(flash_reset),
        .flash_access_block(flash_access_block),
        .slow_read_en(slow_read_en),
        .low_current_read_en(low_current_read_en)
    );

    // ==========================================================
    // helpers
    task automatic close_out;
        if (err_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // compare whole 32-bit values, four-state exact
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask

    // one single transfer: address phase, then data phase, each held until hready
    task automatic bus_xfer(input logic [11:0] addr, input logic wr, input logic [7:0] wdat);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= addr;
        hwrite <= wr;
        hsize <= 3'b010;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= {24'h000000, wdat};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        #1;
        rd_val = rd_smp;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic wr(input logic [11:0] addr, input logic [7:0] wdat);
        bus_xfer(addr, 1'b1, wdat);
    endtask

    task automatic rd(input string what, input logic [11:0] addr, input logic [7:0] exp,
                      input logic [7:0] mask);
        bus_xfer(addr, 1'b0, 8'h00);
        chk(what, {24'h000000, exp & mask}, rd_val & {24'h000000, mask});
    endtask

    task automatic do_reset(input logic boot);
        @(posedge hclk);
        hresetn <= 1'b0;
        user_boot <= boot;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
    endtask

    // ==========================================================
    // watchdog: the whole run is under a hundred cycles
    initial begin
        repeat (3000) @(posedge hclk);
        err_count++;
        close_out();
    end

    // ==========================================================
    // tests
    initial begin
        do_reset(1'b0);
        // reset values; bit 7 reads undefined so it is masked off
        rd("ctrl reset", ctrl_addr, 8'h01, 8'h7f);
        rd("pwr reset", pwr_addr, 8'h00, 8'h0f);
        // sequencer status shows through the read-only flags
        seq_stat.busy <= 1'b1;
        seq_stat.error <= 1'b1;
        rd("ctrl busy error", ctrl_addr, 8'h40, 8'h41);
        seq_stat.busy <= 1'b0;
        seq_stat.error <= 1'b0;
        rd("ctrl ready ok", ctrl_addr, 8'h01, 8'h41);
        // isolated write of 1 to the protected rewrite bit is ignored
        wr(ctrl_addr, 8'h02);
        chk("cmd_accept_en lone", 32'h0, {31'h0, cmd_accept_en});
        wr(ctrl_addr, 8'h00);
        wr(ctrl_addr, 8'h02);
        chk("cmd_accept_en pair", 32'h1, {31'h0, cmd_accept_en});
        // read-only positions keep sequencer values; lock override follows bit 2
        wr(ctrl_addr, 8'hc7);
        rd("ctrl ro ignored", ctrl_addr, 8'h07, 8'h7f);
        chk("lock_override", 32'h1, {31'h0, lock_override});
        // sequencer-owned flags ignore a write of 0 while busy and failed
        seq_stat.busy <= 1'b1;
        seq_stat.error <= 1'b1;
        wr(ctrl_addr, 8'h06);
        rd("ctrl ro kept", ctrl_addr, 8'h46, 8'h7f);
        seq_stat.busy <= 1'b0;
        seq_stat.error <= 1'b0;
        // slow read then low current read, each by its own 0-1 pair
        wr(pwr_addr, 8'h04);
        chk("slow lone", 32'h0, {31'h0, slow_read_en});
        wr(pwr_addr, 8'h00);
        wr(pwr_addr, 8'h04);
        chk("slow pair", 32'h1, {31'h0, slow_read_en});
        // the slow pair wrote 0 to bit 3, so this 1 completes a pair of its own
        wr(pwr_addr, 8'h0c);
        chk("low after zero", 32'h1, {31'h0, low_current_read_en});
        wr(pwr_addr, 8'h04);
        wr(pwr_addr, 8'h0c);
        chk("low pair", 32'h1, {31'h0, low_current_read_en});
        rd("pwr both", pwr_addr, 8'h0c, 8'h0f);
        // halt stops the flash, drops rewrite, masks the read modes
        // bench stands in for code outside the array with read array mode restored
        wr(ctrl_addr, 8'h0e);
        chk("flash_reset", 32'h1, {31'h0, flash_reset});
        chk("access_block", 32'h1, {31'h0, flash_access_block});
        chk("cmd halted", 32'h0, {31'h0, cmd_accept_en});
        chk("slow halted", 32'h0, {31'h0, slow_read_en});
        rd("ctrl halted", ctrl_addr, 8'h0d, 8'h7f);
        wr(ctrl_addr, 8'h04);
        chk("flash_reset off", 32'h0, {31'h0, flash_reset});
        chk("block off", 32'h0, {31'h0, flash_access_block});
        chk("lock kept", 32'h1, {31'h0, lock_override});
        // unmapped word reads zero
        wr(hole_addr, 8'hff);
        rd("unmapped", hole_addr, 8'h00, 8'hff);
        // second reset in user boot mode, registers set beforehand
        do_reset(1'b1);
        rd("ctrl user boot", ctrl_addr, 8'h21, 8'h7f);
        rd("pwr reset 2", pwr_addr, 8'h00, 8'h0f);
        chk("lock reset", 32'h0, {31'h0, lock_override});
        chk("slow reset", 32'h0, {31'h0, slow_read_en});
        // reset leaves bit 3 unarmed, so a lone 1 must not take
        wr(pwr_addr, 8'h08);
        chk("low lone", 32'h0, {31'h0, low_current_read_en});
        close_out();
    end
endmodule // flash_power_control_regs_test
`default_nettype wire
